// ==== sepc_ctrl.sv ====
`timescale 1ns/100ps
// What this block does
// - Writing busy one starts selected operation.
// - Busy holds until done; read data valid.
// - Write without part, data-in low: busy until timeout.
// - Three-bit opcode, reset zero, eight codes.
// - Read fetches addressed byte into data.
// - Disable blocks writes; enable permits them.
// - Write stores data byte at address.
// - Write-all stores data byte everywhere.
// - Erase clears the addressed location.
// - Erase-all clears the whole part.
// - Reload fails unless byte zero is A5h.
// - Failed reload leaves contents unchanged.
// - No response in 30ms: idle, flag.
// - Data-in high, absent part: no timeout.
// - Data-in low: only programming ops time out.
// - Loaded flag set after valid load.
// - Nine-bit byte address, reset zero.
// - Eight-bit data register holds byte.
module sepc_ctrl #(
    parameter int TIMEOUT_CYC = sepc_pkg::TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Serial memory pins
    output logic             prom_cs,
    output logic             prom_sck,
    output logic             prom_dout,
    input  wire logic        prom_serial_data_in,
    // Load result towards the configuration loader
    output logic             load_done
);
    if (TIMEOUT_CYC <= sepc_pkg::SETTLE_CYC || TIMEOUT_CYC > 32'h3fffffff) begin : g_bad_timeout
        $error("TIMEOUT_CYC out of range");
    end

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_SHIFT = 6'b000010,
        ST_RDATA = 6'b000100,
        ST_WDATA = 6'b001000,
        ST_GAP   = 6'b010000,
        ST_POLL  = 6'b100000
    } sepc_state_t;

    typedef struct packed {
        sepc_state_t                       state;
        logic                              busy;
        logic [2:0]                        op;
        logic                              timeout;
        logic                              loaded;
        logic [sepc_pkg::ADDR_W-1:0]       addr;
        logic [sepc_pkg::DATA_W-1:0]       data;
        logic [sepc_pkg::FRAME_W-1:0]      frame;
        logic [3:0]                        bitcnt;
        logic [2:0]                        halfcnt;
        logic [29:0]                       tocnt;
        logic [31:0]                       rdata;
        logic                              cs;
        logic                              sck;
        logic                              dout;
    } sepc_regs_t;

    sepc_regs_t r;
    sepc_regs_t next_r;
    logic       din_s;

    sepc_sync u_din_sync (
        .clk  (clk),
        .srst (srst),
        .din  (prom_serial_data_in),
        .dout (din_s)
    );

    // Serial header: start bit, two opcode bits, nine address bits.
    function automatic logic [sepc_pkg::FRAME_W-1:0] make_frame(input logic [2:0] op,
                                                            input logic [8:0] a);
        logic [1:0] oc;
        logic [8:0] fa;
        oc = 2'h0;
        fa = a;
        unique case (op)
            sepc_pkg::OP_READ,
            sepc_pkg::OP_RELOAD: oc = 2'h2;
            sepc_pkg::OP_WRITE:  oc = 2'h1;
            sepc_pkg::OP_ERASE:  oc = 2'h3;
            sepc_pkg::OP_EW_OFF:    fa = 9'h000;
            sepc_pkg::OP_EW_ON:     fa = 9'h180;
            sepc_pkg::OP_WRITE_ALL: fa = 9'h080;
            sepc_pkg::OP_ERASE_ALL: fa = 9'h100;
        endcase
        if (op == sepc_pkg::OP_RELOAD) begin
            fa = 9'h000;
        end
        return {1'b1, oc, fa};
    endfunction

    function automatic logic is_prog(input logic [2:0] op);
        return op == sepc_pkg::OP_WRITE || op == sepc_pkg::OP_WRITE_ALL ||
               op == sepc_pkg::OP_ERASE || op == sepc_pkg::OP_ERASE_ALL;
    endfunction

    logic half_tick;
    logic fall;
    logic rise;

    always_comb begin
        next_r    = r;
        half_tick = (r.halfcnt == 3'(sepc_pkg::SCK_HALF_CYC - 1));
        rise      = half_tick && !r.sck;
        fall      = half_tick && r.sck;
        next_r.rdata = 32'h0;

        if (reg_rd) begin
            if (reg_addr == sepc_pkg::OFF_CMD) begin
                next_r.rdata[sepc_pkg::POS_BUSY]                      = r.busy;
                next_r.rdata[sepc_pkg::POS_OP_HI:sepc_pkg::POS_OP_LO] = r.op;
                next_r.rdata[sepc_pkg::POS_TIMEOUT]                   = r.timeout;
                next_r.rdata[sepc_pkg::POS_LOADED]                    = r.loaded;
                next_r.rdata[sepc_pkg::ADDR_W-1:0]                    = r.addr;
            end else if (reg_addr == sepc_pkg::OFF_DATA) begin
                next_r.rdata[sepc_pkg::DATA_W-1:0] = r.data;
            end
        end

        if (r.state != ST_IDLE) begin
            next_r.halfcnt = half_tick ? 3'h0 : r.halfcnt + 3'h1;
            if (half_tick) begin
                next_r.sck = !r.sck;
            end
        end

        unique case (r.state)
            ST_IDLE: begin
                next_r.cs  = 1'b0;
                next_r.sck = 1'b0;
                if (reg_wr && reg_addr == sepc_pkg::OFF_CMD) begin
                    next_r.op   = reg_wdata[sepc_pkg::POS_OP_HI:sepc_pkg::POS_OP_LO];
                    next_r.addr = reg_wdata[sepc_pkg::ADDR_W-1:0];
                    if (reg_wdata[sepc_pkg::POS_TIMEOUT]) begin
                        next_r.timeout = 1'b0;
                    end
                    if (reg_wdata[sepc_pkg::POS_BUSY]) begin
                        next_r.busy    = 1'b1;
                        next_r.frame   = make_frame(reg_wdata[sepc_pkg::POS_OP_HI:sepc_pkg::POS_OP_LO],
                                                    reg_wdata[sepc_pkg::ADDR_W-1:0]);
                        next_r.bitcnt  = 4'(sepc_pkg::FRAME_W - 1);
                        next_r.halfcnt = 3'h0;
                        next_r.cs      = 1'b1;
                        next_r.dout    = 1'b1;
                        next_r.state   = ST_SHIFT;
                    end
                end else if (reg_wr && reg_addr == sepc_pkg::OFF_DATA) begin
                    next_r.data = reg_wdata[sepc_pkg::DATA_W-1:0];
                end
            end
            ST_SHIFT: begin
                if (fall) begin
                    if (r.bitcnt == 4'h0) begin
                        if (r.op == sepc_pkg::OP_READ || r.op == sepc_pkg::OP_RELOAD) begin
                            next_r.bitcnt = 4'(sepc_pkg::DATA_W - 1);
                            next_r.state  = ST_RDATA;
                        end else if (r.op == sepc_pkg::OP_WRITE || r.op == sepc_pkg::OP_WRITE_ALL) begin
                            next_r.bitcnt = 4'(sepc_pkg::DATA_W - 1);
                            next_r.dout   = r.data[sepc_pkg::DATA_W-1];
                            next_r.state  = ST_WDATA;
                        end else begin
                            next_r.cs    = 1'b0;
                            next_r.state = ST_GAP;
                        end
                    end else begin
                        next_r.bitcnt = r.bitcnt - 4'h1;
                        next_r.frame  = {r.frame[sepc_pkg::FRAME_W-2:0], 1'b0};
                        next_r.dout   = r.frame[sepc_pkg::FRAME_W-2];
                    end
                end
            end
            ST_RDATA: begin
                if (rise) begin
                    next_r.frame[sepc_pkg::DATA_W-1:0] = {r.frame[sepc_pkg::DATA_W-2:0], din_s};
                end
                if (fall) begin
                    if (r.bitcnt == 4'h0) begin
                        next_r.cs    = 1'b0;
                        next_r.busy  = 1'b0;
                        next_r.state = ST_IDLE;
                        if (r.op == sepc_pkg::OP_READ) begin
                            next_r.data = r.frame[sepc_pkg::DATA_W-1:0];
                        end else if (r.frame[sepc_pkg::DATA_W-1:0] == sepc_pkg::SIGNATURE) begin
                            next_r.loaded = 1'b1;
                        end
                    end else begin
                        next_r.bitcnt = r.bitcnt - 4'h1;
                    end
                end
            end
            ST_WDATA: begin
                if (fall) begin
                    if (r.bitcnt == 4'h0) begin
                        next_r.cs    = 1'b0;
                        next_r.state = ST_GAP;
                    end else begin
                        next_r.bitcnt = r.bitcnt - 4'h1;
                        next_r.dout   = r.data[3'(r.bitcnt - 4'h1)];
                    end
                end
            end
            ST_GAP: begin
                // Select stays low for half a serial clock so the part can start its program cycle.
                next_r.sck = 1'b0;
                if (rise) begin
                    if (is_prog(r.op)) begin
                        next_r.cs    = 1'b1;
                        next_r.tocnt = 30'h0;
                        next_r.state = ST_POLL;
                    end else begin
                        next_r.busy  = 1'b0;
                        next_r.state = ST_IDLE;
                    end
                end
            end
            ST_POLL: begin
                // Ready counts only once the synchroniser holds a level sampled after select rose.
                next_r.sck   = 1'b0;
                next_r.dout  = 1'b0;
                next_r.tocnt = r.tocnt + 30'h1;
                if (din_s && r.tocnt >= 30'(sepc_pkg::SETTLE_CYC - 1)) begin
                    next_r.cs    = 1'b0;
                    next_r.busy  = 1'b0;
                    next_r.state = ST_IDLE;
                end else if (r.tocnt == 30'(TIMEOUT_CYC - 1)) begin
                    next_r.cs      = 1'b0;
                    next_r.busy    = 1'b0;
                    next_r.timeout = 1'b1;
                    next_r.state   = ST_IDLE;
                end
            end
            default: begin
                next_r.state = ST_IDLE;
                next_r.busy  = 1'b0;
                next_r.cs    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r       <= '0;
            r.state <= ST_IDLE;
            r.op    <= sepc_pkg::OP_RESET;
            r.addr  <= sepc_pkg::ADDR_RESET;
        end else begin
            r <= next_r;
        end
    end

    // A failed reload touches neither data nor the loaded flag.
    assign reg_rdata = r.rdata;
    assign prom_cs   = r.cs;
    assign prom_sck  = r.sck;
    assign prom_dout = r.dout;
    assign load_done = r.loaded;

    property p_start;
        @(posedge clk) disable iff (srst)
        (r.state == ST_IDLE && reg_wr && reg_addr == sepc_pkg::OFF_CMD && reg_wdata[sepc_pkg::POS_BUSY])
            |=> (r.busy && prom_cs);
    endproperty
    a_start: assert property (p_start) else $error("busy write did not start");

    property p_busy_hold;
        @(posedge clk) disable iff (srst)
        (r.state != ST_IDLE) |-> r.busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped mid operation");

    property p_timeout;
        @(posedge clk) disable iff (srst)
        (r.state == ST_POLL && !din_s && r.tocnt == 30'(TIMEOUT_CYC - 1))
            |=> (!r.busy && r.timeout && r.state == ST_IDLE);
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout did not end operation");

    property p_to_clear;
        @(posedge clk) disable iff (srst)
        (r.state == ST_IDLE && reg_wr && reg_addr == sepc_pkg::OFF_CMD && reg_wdata[sepc_pkg::POS_TIMEOUT])
            |=> !r.timeout;
    endproperty
    a_to_clear: assert property (p_to_clear) else $error("timeout flag not cleared");

    property p_no_to_nonprog;
        @(posedge clk) disable iff (srst)
        $rose(r.timeout) |-> is_prog(r.op);
    endproperty
    a_no_to_nonprog: assert property (p_no_to_nonprog) else $error("non programming op timed out");

    sequence s_poll_release;
        !r.busy && $stable(r.timeout) ##1 !prom_cs;
    endsequence

    property p_poll_high;
        @(posedge clk) disable iff (srst)
        (r.state == ST_POLL && din_s && r.tocnt >= 30'(sepc_pkg::SETTLE_CYC - 1)) |=> s_poll_release;
    endproperty
    a_poll_high: assert property (p_poll_high) else $error("ready line ignored");

    property p_loaded_sig;
        @(posedge clk) disable iff (srst)
        $rose(r.loaded) |-> $past(r.op) == sepc_pkg::OP_RELOAD && $past(r.frame[7:0]) == sepc_pkg::SIGNATURE;
    endproperty
    a_loaded_sig: assert property (p_loaded_sig) else $error("loaded without signature");

    property p_data_stable;
        @(posedge clk) disable iff (srst)
        (r.busy && r.op != sepc_pkg::OP_READ) |=> $stable(r.data);
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("data changed during operation");

    property p_rd_latency;
        @(posedge clk) disable iff (srst)
        (reg_rd && reg_addr == sepc_pkg::OFF_DATA) |=> reg_rdata[7:0] == $past(r.data);
    endproperty
    a_rd_latency: assert property (p_rd_latency) else $error("data read wrong");
endmodule

// ==== sepc_pkg.sv ====
package sepc_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CMD        = 8'h40;
    localparam logic [7:0] OFF_DATA       = 8'h44;
    // Command register field positions.
    localparam int         POS_BUSY       = 31;
    localparam int         POS_OP_HI      = 30;
    localparam int         POS_OP_LO      = 28;
    localparam int         POS_TIMEOUT    = 10;
    localparam int         POS_LOADED     = 9;
    localparam int         ADDR_W         = 9;
    localparam int         DATA_W         = 8;
    // Reset values.
    localparam logic [2:0] OP_RESET       = 3'h0;
    localparam logic [8:0] ADDR_RESET     = 9'h000;
    // Operation codes.
    localparam logic [2:0] OP_READ        = 3'h0;
    localparam logic [2:0] OP_EW_OFF      = 3'h1;
    localparam logic [2:0] OP_EW_ON       = 3'h2;
    localparam logic [2:0] OP_WRITE       = 3'h3;
    localparam logic [2:0] OP_WRITE_ALL   = 3'h4;
    localparam logic [2:0] OP_ERASE       = 3'h5;
    localparam logic [2:0] OP_ERASE_ALL   = 3'h6;
    localparam logic [2:0] OP_RELOAD      = 3'h7;
    // Signature expected at byte zero of a programmed part.
    localparam logic [7:0] SIGNATURE      = 8'ha5;
    // Timing.
    localparam int         CLK_MHZ        = 125;
    localparam int         TIMEOUT_MS     = 30;
    localparam int         TIMEOUT_CYC    = TIMEOUT_MS * CLK_MHZ * 1000;
    localparam int         SCK_HALF_CYC   = 4;
    localparam int         SETTLE_CYC     = 4;
    // Serial frame: start bit, 2-bit opcode, address.
    localparam int         FRAME_W        = 1 + 2 + ADDR_W;
endpackage

// ==== sepc_sync.sv ====
`timescale 1ns/100ps
// Three-stage input synchroniser; the output moves once stages two and three agree.
module sepc_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Data
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } sepc_sync_t;

    sepc_sync_t st;
    sepc_sync_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.q = st.s3;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, q: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign dout = (st.s2 == st.s3) ? st.s3 : st.q;
endmodule

// ==== sepc_prom_model.sv ====
`timescale 1ns/100ps
// Behavioural serial memory: samples on the serial clock rise, answers on its fall, shows busy while programming.
module sepc_prom_model (
    // Clock
    input  wire logic clk,
    // Serial pins
    input  wire logic cs,
    input  wire logic sck,
    input  wire logic di,
    output logic      do_pin,
    // Board options
    input  wire logic present,
    input  wire logic pull_hi
);
    logic [7:0]  mem [512];
    logic [19:0] sh;
    logic [11:0] hdr;
    logic [7:0]  rd_sh;
    logic        rd_bit;
    logic        rd_on;
    logic        ew_en;
    logic        polling;
    logic        prog;
    int          n;
    int          busy_cnt;

    initial begin
        for (int i = 0; i < 512; i++) mem[i] = 8'hff;
        ew_en = 1'b0;
        {sh, hdr, rd_sh, rd_bit, rd_on, polling, prog} = '0;
        n = 0;
        busy_cnt = 0;
    end

    always @(posedge sck) begin
        if (cs) begin
            sh = {sh[18:0], di};
            n = n + 1;
            if (n == 12) begin
                hdr = sh[11:0];
                rd_sh = mem[sh[8:0]];
            end
        end
    end

    always @(negedge sck) begin
        if (cs && n >= 12 && hdr[10:9] == 2'b10) begin
            rd_bit = rd_sh[7];
            rd_sh = {rd_sh[6:0], 1'b0};
            rd_on = 1'b1;
        end
    end

    // A part that is write-protected ignores programming but still reports ready at once.
    always @(negedge cs) begin
        polling = 1'b0;
        prog = 1'b0;
        if (n >= 12) begin
            case (hdr[10:9])
                2'b00: begin
                    if (hdr[8:7] == 2'b11) ew_en = 1'b1;
                    if (hdr[8:7] == 2'b00) ew_en = 1'b0;
                    if (hdr[8:7] == 2'b01 && n >= 20) begin
                        prog = 1'b1;
                        if (ew_en) for (int i = 0; i < 512; i++) mem[i] = sh[7:0];
                    end
                    if (hdr[8:7] == 2'b10) begin
                        prog = 1'b1;
                        if (ew_en) for (int i = 0; i < 512; i++) mem[i] = 8'hff;
                    end
                end
                2'b01: if (n >= 20) begin
                    prog = 1'b1;
                    if (ew_en) mem[hdr[8:0]] = sh[7:0];
                end
                2'b11: begin
                    prog = 1'b1;
                    if (ew_en) mem[hdr[8:0]] = 8'hff;
                end
                default: ;
            endcase
        end
        polling = prog;
        if (prog && ew_en) busy_cnt = 20;
        n = 0;
        rd_on = 1'b0;
    end

    always @(posedge clk) begin
        if (busy_cnt > 0) busy_cnt = busy_cnt - 1;
    end

    assign do_pin = !present ? pull_hi : (cs && rd_on) ? rd_bit : (cs && polling) ? (busy_cnt == 0) : pull_hi;
endmodule

// ==== test_serial_eeprom_command_controller.sv ====
`timescale 1ns/100ps
module test_serial_eeprom_command_controller;
    localparam int TO_CYC = 50;
    localparam int LIMIT  = 60000;
    logic        clk;
    logic        srst;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        prom_cs;
    logic        prom_sck;
    logic        prom_dout;
    logic        din;
    logic        load_done;
    logic        present;
    logic        pull_hi;
    int          n_mismatch;
    int          tests_run;
    int          cyc;

    sepc_ctrl #(.TIMEOUT_CYC(TO_CYC)) DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prom_cs(prom_cs), .prom_sck(prom_sck),
        .prom_dout(prom_dout), .prom_serial_data_in(din), .load_done(load_done));
    sepc_prom_model prom (.clk(clk), .cs(prom_cs), .sck(prom_sck), .di(prom_dout), .do_pin(din),
        .present(present), .pull_hi(pull_hi));

    always #4 clk = ~clk;

    task conclude();
        $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch = n_mismatch + 1;
            conclude();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task cmd(input logic [2:0] op, input logic [8:0] a, output int t);
        logic [31:0] v;
        int          t0;
        wr(sepc_pkg::OFF_CMD, {1'b1, op, 19'h0, a});
        t0 = cyc;
        rd(sepc_pkg::OFF_CMD, v);
        chk(v[31], 1'b1);
        for (int i = 0; i < 500 && v[31] !== 1'b0; i++) rd(sepc_pkg::OFF_CMD, v);
        t = cyc - t0;
        chk(v[31], 1'b0);
    endtask

    task prog(input logic [2:0] op, input logic [8:0] a, input logic [7:0] d);
        int t;
        wr(sepc_pkg::OFF_DATA, {24'h0, d});
        cmd(op, a, t);
    endtask

    task rd_byte(input logic [8:0] a, input logic [7:0] exp);
        logic [31:0] v;
        int          t;
        cmd(sepc_pkg::OP_READ, a, t);
        rd(sepc_pkg::OFF_DATA, v);
        chk(v, {24'h0, exp});
    endtask

    task t_reset();
        logic [31:0] v;
        wr(8'h48, 32'hffffffff);
        rd(sepc_pkg::OFF_CMD, v);
        chk(v, 32'h0);
        rd(8'h48, v);
        chk(v, 32'h0);
    endtask

    task t_program();
        logic [31:0] v;
        int          t;
        prog(sepc_pkg::OP_WRITE, 9'h003, 8'h11);
        rd_byte(9'h003, 8'hff);
        cmd(sepc_pkg::OP_EW_ON, 9'h000, t);
        prog(sepc_pkg::OP_WRITE, 9'h1a5, 8'h3c);
        rd(sepc_pkg::OFF_CMD, v);
        chk(v, {1'b0, sepc_pkg::OP_WRITE, 19'h0, 9'h1a5});
        rd_byte(9'h1a5, 8'h3c);
        prog(sepc_pkg::OP_ERASE, 9'h1a5, 8'h00);
        rd_byte(9'h1a5, 8'hff);
        prog(sepc_pkg::OP_WRITE_ALL, 9'h000, 8'h5a);
        rd_byte(9'h000, 8'h5a);
        rd_byte(9'h1ff, 8'h5a);
    endtask

    task t_reload();
        logic [31:0] v;
        int          t;
        cmd(sepc_pkg::OP_RELOAD, 9'h000, t);
        rd(sepc_pkg::OFF_CMD, v);
        chk(v[9], 1'b0);
        chk(load_done, 1'b0);
        rd(sepc_pkg::OFF_DATA, v);
        chk(v, 32'h5a);
        prog(sepc_pkg::OP_WRITE, 9'h000, sepc_pkg::SIGNATURE);
        cmd(sepc_pkg::OP_RELOAD, 9'h000, t);
        rd(sepc_pkg::OFF_CMD, v);
        chk(v[9], 1'b1);
        chk(load_done, 1'b1);
        prog(sepc_pkg::OP_ERASE_ALL, 9'h000, 8'h00);
        rd_byte(9'h007, 8'hff);
        cmd(sepc_pkg::OP_EW_OFF, 9'h000, t);
        prog(sepc_pkg::OP_WRITE, 9'h007, 8'h11);
        rd_byte(9'h007, 8'hff);
    endtask

    // Every code with the part missing: only programming codes may time out, and only with data-in low.
    task t_absent();
        logic [31:0] v;
        logic        exp;
        int          t;
        int          lo;
        present <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            pull_hi <= p[0];
            for (int i = 0; i < 8; i++) begin
                exp = !p[0] && (i == 3 || i == 4 || i == 5 || i == 6);
                wr(sepc_pkg::OFF_DATA, 32'h33);
                cmd(i[2:0], 9'h002, t);
                rd(sepc_pkg::OFF_CMD, v);
                chk(v[10], exp);
                if (i == 7) chk(v[9], 1'b1);
                lo = (i == 3 || i == 4) ? sepc_pkg::DATA_W : 0;
                lo = (sepc_pkg::FRAME_W + lo) * 2 * sepc_pkg::SCK_HALF_CYC + sepc_pkg::SCK_HALF_CYC + TO_CYC;
                if (exp) chk(t >= lo && t <= lo + 4, 1'b1);
                wr(sepc_pkg::OFF_CMD, 32'h00000402);
                rd(sepc_pkg::OFF_CMD, v);
                chk(v[10], 1'b0);
            end
        end
        present <= 1'b1;
        pull_hi <= 1'b1;
    endtask

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        present = 1'b1;
        pull_hi = 1'b1;
        n_mismatch = 0;
        tests_run = 0;
        cyc = 0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_program();
        t_reload();
        t_absent();
        conclude();
    end
endmodule
